//--- dmad_regs.vh
// constants for the multiply / alu datapath
`ifndef DMAD_REGS_VH
`define DMAD_REGS_VH

// operation codes presented on OP
`define DMAD_OP_W            6
`define DMAD_OP_NOP          6'h00
`define DMAD_OP_LOAD_MULT    6'h01
`define DMAD_OP_MUL          6'h02
`define DMAD_OP_MUL_IMM      6'h03
`define DMAD_OP_UMUL         6'h04
`define DMAD_OP_SQAD         6'h05
`define DMAD_OP_SQSB         6'h06
`define DMAD_OP_PHLD         6'h07
`define DMAD_OP_PSTH         6'h08
`define DMAD_OP_PSTL         6'h09
`define DMAD_OP_LOAD_ACC     6'h0a
`define DMAD_OP_LOAD_ACC_VAR 6'h0b
`define DMAD_OP_ADD          6'h0c
`define DMAD_OP_ADD_VAR      6'h0d
`define DMAD_OP_SUB          6'h0e
`define DMAD_OP_SUB_VAR      6'h0f
`define DMAD_OP_ADCY         6'h10
`define DMAD_OP_SBCY         6'h11
`define DMAD_OP_AND          6'h12
`define DMAD_OP_OR           6'h13
`define DMAD_OP_XOR          6'h14
`define DMAD_OP_ADD_PROD     6'h15
`define DMAD_OP_SUB_PROD     6'h16
`define DMAD_OP_LOAD_PROD    6'h17
`define DMAD_OP_BIT          6'h18
`define DMAD_OP_BIT_VAR      6'h19
`define DMAD_OP_LEADING_SHIFT_OP         6'h1a
`define DMAD_OP_JUMP_ACC     6'h1b
`define DMAD_OP_SHL          6'h1c
`define DMAD_OP_SHR          6'h1d
`define DMAD_OP_RLC          6'h1e
`define DMAD_OP_RRC          6'h1f
`define DMAD_OP_SET_CARRY    6'h20
`define DMAD_OP_CLR_CARRY    6'h21
`define DMAD_OP_LOAD_STATUS1 6'h22
`define DMAD_OP_STORE_HIGH   6'h23
`define DMAD_OP_STORE_LOW    6'h24

// product shift modes
`define DMAD_PS_NONE         2'h0
`define DMAD_PS_LEFT1        2'h1
`define DMAD_PS_LEFT4        2'h2
`define DMAD_PS_RIGHT6       2'h3

// aux load sources and post-modify modes
`define DMAD_SRC_MEM         2'h0
`define DMAD_SRC_ACC         2'h1
`define DMAD_SRC_PROD        2'h2
`define DMAD_SRC_IMM         2'h3
`define DMAD_MOD_NONE        2'h0
`define DMAD_MOD_INC         2'h1
`define DMAD_MOD_DEC         2'h2
`define DMAD_MOD_INDEX       2'h3

// saturation values and special counts
`define DMAD_SAT_POS         32'h7fffffff
`define DMAD_SAT_NEG         32'h80000000
`define DMAD_HIGH_SHIFT      5'h10
`define DMAD_STATUS1_CARRY   9

// reset values
`define DMAD_RST_CARRY       1'b1
`define DMAD_RST_WORD        16'h0000
`define DMAD_RST_ACC         32'h00000000

`endif

//--- dmad_aux_file.v
// auxiliary register file with registered read ports
`timescale 1ns/1ps
module dmad_aux_file #(
    parameter W  = 16,
    parameter N  = 8,
    parameter AW = 3
) (
    // clock and reset
    input  wire          clk,
    input  wire          rst,
    // write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [W-1:0]  wr_data,
    // read port and index register
    input  wire [AW-1:0] rd_addr,
    output reg  [W-1:0]  rd_data,
    output reg  [W-1:0]  idx_data
);
    reg [W-1:0] mem [0:N-1];
    integer     i;

    // forwarding keeps a same-cycle write visible on the next read
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < N; i = i + 1)
                mem[i] <= {W{1'b0}};
            rd_data  <= {W{1'b0}};
            idx_data <= {W{1'b0}};
        end else begin
            if (wr_en)
                mem[wr_addr] <= wr_data;
            if (wr_en && wr_addr == rd_addr)
                rd_data <= wr_data;
            else
                rd_data <= mem[rd_addr];
            if (wr_en && wr_addr == {AW{1'b0}})
                idx_data <= wr_data;
            else
                idx_data <= mem[0];
        end
    end
endmodule // dmad_aux_file

//--- dmad_datapath.v
// multiplier, central alu, accumulator and aux address datapath
`timescale 1ns/1ps
`include "dmad_regs.vh"
module dmad_datapath (
    // clock and reset
    input  wire        CLK_SYS,
    input  wire        RST,
    // decoded operation
    input  wire [5:0]  OP,
    input  wire [4:0]  SHIFT_CNT,
    input  wire [2:0]  POST_SHIFT,
    input  wire        SRC_PROG,
    input  wire [15:0] IMM,
    // read buses
    input  wire [15:0] DATA_READ_BUS,
    input  wire [15:0] PROGRAM_READ_BUS,
    // mode bits
    input  wire        SATURATE_ENABLE,
    input  wire        SIGN_EXTEND_ENABLE,
    input  wire [1:0]  PRODUCT_SHIFT_MODE,
    input  wire        OVERFLOW_CLEAR,
    // aux register control
    input  wire        AUX_LOAD,
    input  wire [2:0]  AUX_LOAD_SEL,
    input  wire [1:0]  AUX_SRC,
    input  wire        AUX_PTR_LOAD,
    input  wire        AUX_ACCESS,
    input  wire [1:0]  AUX_MOD,
    // datapath state
    output wire [31:0] ACC,
    output wire [31:0] PRODUCT,
    output wire [15:0] MULT_OPERAND,
    output wire        CARRY,
    output wire        OVERFLOW,
    output wire        ZERO_COND,
    output wire        TEST_FLAG,
    // store, jump and address outputs
    output wire [15:0] STORE_DATA,
    output wire        STORE_VALID,
    output wire [15:0] JUMP_ADDR,
    output wire        JUMP_VALID,
    output wire [15:0] AUX_ADDR,
    output wire        AUX_ADDR_VALID,
    output wire [2:0]  AUX_PTR
);
    reg  [31:0] acc_ff;
    reg  [31:0] prod_ff;
    reg  [15:0] topnd_ff;
    reg         carry_ff;
    reg         ovf_ff;
    reg         test_ff;
    reg  [15:0] store_ff;
    reg         store_vld_ff;
    reg  [15:0] jump_ff;
    reg         jump_vld_ff;
    reg  [15:0] aaddr_ff;
    reg         aaddr_vld_ff;
    reg  [2:0]  ptr_ff;

    reg  [31:0] nxt_acc;
    reg  [31:0] nxt_prod;
    reg  [15:0] nxt_topnd;
    reg         nxt_carry;
    reg         nxt_test;
    reg  [15:0] nxt_store;
    reg         nxt_store_vld;
    reg         ovf_evt;

    // adder and multiplier controls set by decode
    reg  [31:0] alu_b;
    reg         alu_sub;
    reg         alu_usec;
    reg         alu_arith;
    reg         alu_high;
    reg         mul_en;
    reg         mul_uns;
    reg  [15:0] mul_x;
    reg  [15:0] mul_y;

    // extends the data word, sign or zero, and scales it left by the shift count
    function [31:0] scale_in;
        input [15:0] d;
        input [4:0]  n;
        input        sx;
        reg   [31:0] e;
        begin
            e = {{16{sx & d[15]}}, d};
            scale_in = e << n;
        end
    endfunction

    function [31:0] prod_shift;
        input [31:0] p;
        input [1:0]  m;
        begin
            case (m)
                `DMAD_PS_LEFT1:  prod_shift = {p[30:0], 1'b0};
                `DMAD_PS_LEFT4:  prod_shift = {p[27:0], 4'h0};
                `DMAD_PS_RIGHT6: prod_shift = {{6{p[31]}}, p[31:6]};
                default:         prod_shift = p;
            endcase
        end
    endfunction

    wire [15:0] din     = SRC_PROG ? PROGRAM_READ_BUS : DATA_READ_BUS;
    // every product transfer except the aux load from the product sees the shifter
    wire [31:0] prod_sh = prod_shift(prod_ff, PRODUCT_SHIFT_MODE);
    // postscale is a view, accumulator never written here
    wire [31:0] post_sh = acc_ff << POST_SHIFT;
    wire [3:0]  tshift  = topnd_ff[3:0];

    // extension bit zero for unsigned, sign otherwise
    wire signed [16:0] mul_a = {~mul_uns & mul_x[15], mul_x};
    wire signed [16:0] mul_b = {~mul_uns & mul_y[15], mul_y};
    wire signed [33:0] mul_p = mul_a * mul_b;

    // single adder; subtract adds the complement with carry in
    wire [31:0] alu_be  = alu_sub ? ~alu_b : alu_b;
    wire        alu_cin = alu_usec ? carry_ff : alu_sub;
    wire [32:0] alu_sum = {1'b0, acc_ff} + {1'b0, alu_be} +
                          {32'h00000000, alu_cin};
    wire        alu_ovf = (acc_ff[31] == alu_be[31]) &&
                          (alu_sum[31] != acc_ff[31]);

    always @* begin
        alu_b     = 32'h00000000;
        alu_sub   = 1'b0;
        alu_usec  = 1'b0;
        alu_arith = 1'b0;
        alu_high  = 1'b0;
        mul_en    = 1'b0;
        mul_uns   = 1'b0;
        mul_x     = topnd_ff;
        mul_y     = din;
        case (OP)
            `DMAD_OP_MUL: begin
                mul_en = 1'b1;
            end
            // immediate 0 clears, immediate 1 copies operand reg
            `DMAD_OP_MUL_IMM: begin
                mul_en = 1'b1;
                mul_y  = IMM;
            end
            `DMAD_OP_UMUL: begin
                mul_en  = 1'b1;
                mul_uns = 1'b1;
            end
            // square of the data word, old product accumulated
            `DMAD_OP_SQAD, `DMAD_OP_SQSB: begin
                mul_en    = 1'b1;
                mul_x     = din;
                alu_b     = prod_sh;
                alu_sub   = (OP == `DMAD_OP_SQSB);
                alu_arith = 1'b1;
            end
            `DMAD_OP_ADD, `DMAD_OP_SUB: begin
                alu_b     = scale_in(din, SHIFT_CNT, SIGN_EXTEND_ENABLE);
                alu_sub   = (OP == `DMAD_OP_SUB);
                alu_arith = 1'b1;
                alu_high  = (SHIFT_CNT == `DMAD_HIGH_SHIFT);
            end
            `DMAD_OP_ADD_VAR, `DMAD_OP_SUB_VAR: begin
                alu_b     = scale_in(din, {1'b0, tshift},
                                     SIGN_EXTEND_ENABLE);
                alu_sub   = (OP == `DMAD_OP_SUB_VAR);
                alu_arith = 1'b1;
            end
            // stored carry joins the sum; operand unextended
            `DMAD_OP_ADCY, `DMAD_OP_SBCY: begin
                alu_b     = {16'h0000, din};
                alu_sub   = (OP == `DMAD_OP_SBCY);
                alu_usec  = 1'b1;
                alu_arith = 1'b1;
            end
            `DMAD_OP_ADD_PROD, `DMAD_OP_SUB_PROD: begin
                alu_b     = prod_sh;
                alu_sub   = (OP == `DMAD_OP_SUB_PROD);
                alu_arith = 1'b1;
            end
            default: begin
                alu_b = 32'h00000000;
            end
        endcase
    end

    always @* begin
        nxt_acc       = acc_ff;
        nxt_prod      = prod_ff;
        nxt_topnd     = topnd_ff;
        nxt_carry     = carry_ff;
        nxt_test      = test_ff;
        nxt_store     = store_ff;
        nxt_store_vld = 1'b0;
        ovf_evt       = 1'b0;
        if (mul_en)
            nxt_prod = mul_p[31:0];
        if (alu_arith) begin
            ovf_evt = alu_ovf;
            if (SATURATE_ENABLE && alu_ovf)
                nxt_acc = acc_ff[31] ? `DMAD_SAT_NEG : `DMAD_SAT_POS;
            else
                nxt_acc = alu_sum[31:0];
            // high-half add/sub touch carry one way only
            if (alu_high && !alu_sub)
                nxt_carry = carry_ff | alu_sum[32];
            else if (alu_high)
                nxt_carry = carry_ff & alu_sum[32];
            else
                nxt_carry = alu_sum[32];
        end
        case (OP)
            `DMAD_OP_LOAD_MULT: nxt_topnd = din;
            `DMAD_OP_PHLD:      nxt_prod = {din, prod_ff[15:0]};
            `DMAD_OP_PSTH: begin
                nxt_store     = prod_sh[31:16];
                nxt_store_vld = 1'b1;
            end
            `DMAD_OP_PSTL: begin
                nxt_store     = prod_sh[15:0];
                nxt_store_vld = 1'b1;
            end
            `DMAD_OP_LOAD_ACC:
                nxt_acc = scale_in(din, SHIFT_CNT, SIGN_EXTEND_ENABLE);
            `DMAD_OP_LOAD_ACC_VAR:
                nxt_acc = scale_in(din, {1'b0, tshift},
                                   SIGN_EXTEND_ENABLE);
            `DMAD_OP_LOAD_PROD: nxt_acc = prod_sh;
            // logic ops raise no overflow, carry untouched
            `DMAD_OP_AND:
                nxt_acc = acc_ff & scale_in(din, SHIFT_CNT, 1'b0);
            `DMAD_OP_OR:
                nxt_acc = acc_ff | scale_in(din, SHIFT_CNT, 1'b0);
            `DMAD_OP_XOR:
                nxt_acc = acc_ff ^ scale_in(din, SHIFT_CNT, 1'b0);
            // bit tests write only the test flag
            `DMAD_OP_BIT:       nxt_test = din[4'hf - IMM[3:0]];
            `DMAD_OP_BIT_VAR:   nxt_test = din[4'hf - tshift];
            // one normalising left step per issue
            `DMAD_OP_LEADING_SHIFT_OP: begin
                nxt_test = acc_ff[31] ^ acc_ff[30];
                if (!nxt_test && acc_ff != `DMAD_RST_ACC)
                    nxt_acc = {acc_ff[30:0], 1'b0};
            end
            // shifts and rotates through the carry
            `DMAD_OP_SHL: begin
                nxt_carry = acc_ff[31];
                nxt_acc   = {acc_ff[30:0], 1'b0};
            end
            `DMAD_OP_SHR: begin
                nxt_carry = acc_ff[0];
                nxt_acc   = {SIGN_EXTEND_ENABLE & acc_ff[31],
                             acc_ff[31:1]};
            end
            `DMAD_OP_RLC: begin
                nxt_carry = acc_ff[31];
                nxt_acc   = {acc_ff[30:0], carry_ff};
            end
            `DMAD_OP_RRC: begin
                nxt_carry = acc_ff[0];
                nxt_acc   = {carry_ff, acc_ff[31:1]};
            end
            // carry set, cleared and loaded from status word
            `DMAD_OP_SET_CARRY:    nxt_carry = 1'b1;
            `DMAD_OP_CLR_CARRY:    nxt_carry = 1'b0;
            `DMAD_OP_LOAD_STATUS1: nxt_carry = din[`DMAD_STATUS1_CARRY];
            // high half takes low-word bits, low half zero-fills
            `DMAD_OP_STORE_HIGH: begin
                nxt_store     = post_sh[31:16];
                nxt_store_vld = 1'b1;
            end
            `DMAD_OP_STORE_LOW: begin
                nxt_store     = post_sh[15:0];
                nxt_store_vld = 1'b1;
            end
            default: nxt_store_vld = 1'b0;
        endcase
    end

    reg  [15:0] aux_src;
    always @* begin
        case (AUX_SRC)
            `DMAD_SRC_MEM:  aux_src = din;
            `DMAD_SRC_ACC:  aux_src = acc_ff[15:0];
            `DMAD_SRC_PROD: aux_src = prod_ff[15:0];
            default:        aux_src = IMM;
        endcase
    end

    wire [2:0]  nxt_ptr = AUX_PTR_LOAD ? aux_src[2:0] : ptr_ff;
    wire [15:0] aux_cur;
    wire [15:0] aux_idx;
    reg  [15:0] aux_mod;
    always @* begin
        case (AUX_MOD)
            `DMAD_MOD_INC:   aux_mod = aux_cur + 16'h0001;
            `DMAD_MOD_DEC:   aux_mod = aux_cur - 16'h0001;
            `DMAD_MOD_INDEX: aux_mod = aux_cur + aux_idx;
            default:         aux_mod = aux_cur;
        endcase
    end
    // an explicit load outranks the post-modify write
    wire        aux_mod_wr = AUX_ACCESS && AUX_MOD != `DMAD_MOD_NONE;
    wire        aux_wr     = AUX_LOAD | aux_mod_wr;
    wire [2:0]  aux_wa     = AUX_LOAD ? AUX_LOAD_SEL : ptr_ff;
    wire [15:0] aux_wd     = AUX_LOAD ? aux_src : aux_mod;

    dmad_aux_file #(
        .W  (16),
        .N  (8),
        .AW (3)
    ) u_aux (
        .clk      (CLK_SYS),
        .rst      (RST),
        .wr_en    (aux_wr),
        .wr_addr  (aux_wa),
        .wr_data  (aux_wd),
        .rd_addr  (nxt_ptr),
        .rd_data  (aux_cur),
        .idx_data (aux_idx)
    );

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            acc_ff       <= `DMAD_RST_ACC;
            prod_ff      <= `DMAD_RST_ACC;
            topnd_ff     <= `DMAD_RST_WORD;
            carry_ff     <= `DMAD_RST_CARRY;
            ovf_ff       <= 1'b0;
            test_ff      <= 1'b0;
            store_ff     <= `DMAD_RST_WORD;
            store_vld_ff <= 1'b0;
            jump_ff      <= `DMAD_RST_WORD;
            jump_vld_ff  <= 1'b0;
            aaddr_ff     <= `DMAD_RST_WORD;
            aaddr_vld_ff <= 1'b0;
            ptr_ff       <= 3'h0;
        end else begin
            acc_ff       <= nxt_acc;
            prod_ff      <= nxt_prod;
            topnd_ff     <= nxt_topnd;
            carry_ff     <= nxt_carry;
            test_ff      <= nxt_test;
            store_ff     <= nxt_store;
            store_vld_ff <= nxt_store_vld;
            // sticky flag, a new overflow beats the clear
            ovf_ff       <= ovf_evt | (ovf_ff & ~OVERFLOW_CLEAR);
            jump_vld_ff  <= (OP == `DMAD_OP_JUMP_ACC);
            if (OP == `DMAD_OP_JUMP_ACC)
                jump_ff <= acc_ff[15:0];
            aaddr_vld_ff <= AUX_ACCESS;
            if (AUX_ACCESS)
                aaddr_ff <= aux_cur;
            ptr_ff       <= nxt_ptr;
        end
    end

    assign ACC            = acc_ff;
    assign PRODUCT        = prod_ff;
    assign MULT_OPERAND   = topnd_ff;
    assign CARRY          = carry_ff;
    assign OVERFLOW       = ovf_ff;
    assign ZERO_COND      = (acc_ff == `DMAD_RST_ACC);
    assign TEST_FLAG      = test_ff;
    assign STORE_DATA     = store_ff;
    assign STORE_VALID    = store_vld_ff;
    assign JUMP_ADDR      = jump_ff;
    assign JUMP_VALID     = jump_vld_ff;
    assign AUX_ADDR       = aaddr_ff;
    assign AUX_ADDR_VALID = aaddr_vld_ff;
    assign AUX_PTR        = ptr_ff;
endmodule // dmad_datapath

//--- dmad_datapath_asserts.sv
// assertions on the datapath top ports
`timescale 1ns/1ps
`include "dmad_regs.vh"
module dmad_datapath_asserts (
    // clock and reset
    input wire        CLK_SYS,
    input wire        RST,
    // operation inputs
    input wire [5:0]  OP,
    input wire [15:0] IMM,
    input wire [2:0]  POST_SHIFT,
    input wire [15:0] DATA_READ_BUS,
    input wire        AUX_ACCESS,
    // datapath state
    input wire [31:0] ACC,
    input wire [31:0] PRODUCT,
    input wire [15:0] MULT_OPERAND,
    input wire        CARRY,
    input wire [15:0] STORE_DATA,
    input wire        STORE_VALID,
    input wire [15:0] JUMP_ADDR,
    input wire        JUMP_VALID,
    input wire        AUX_ADDR_VALID
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // store path view; the accumulator itself must not move
    wire [31:0] acc_sh = ACC << POST_SHIFT;
    reset_carry_a: assert property (
        $fell(RST) |-> CARRY && ACC == 32'h0) else $error("reset state");
    umul_prod_a: assert property (
        OP == `DMAD_OP_UMUL |=>
        PRODUCT == $past(MULT_OPERAND) * $past(DATA_READ_BUS))
        else $error("unsigned product");
    mul_zero_a: assert property (
        OP == `DMAD_OP_MUL_IMM && IMM == 16'h0 |=> PRODUCT == 32'h0)
        else $error("product not cleared");
    bit_keep_a: assert property (
        OP == `DMAD_OP_BIT || OP == `DMAD_OP_BIT_VAR |=> $stable(ACC))
        else $error("bit test moved acc");
    store_high_a: assert property (
        OP == `DMAD_OP_STORE_HIGH |=> STORE_VALID && $stable(ACC) &&
        STORE_DATA == $past(acc_sh[31:16])) else $error("store high");
    logic_carry_a: assert property (
        OP == `DMAD_OP_AND || OP == `DMAD_OP_OR || OP == `DMAD_OP_XOR
        |=> $stable(CARRY)) else $error("logic op moved carry");
    jump_addr_a: assert property (
        OP == `DMAD_OP_JUMP_ACC |=> JUMP_VALID &&
        JUMP_ADDR == $past(ACC[15:0])) else $error("jump address");
    aux_valid_a: assert property (
        AUX_ACCESS |=> AUX_ADDR_VALID) else $error("aux address valid");
endmodule // dmad_datapath_asserts

//--- dmad_mem_model.sv
// data memory model feeding the read buses and taking stores
`timescale 1ns/1ps
module dmad_mem_model (
    // clock and read select
    input  wire        clk,
    input  wire [3:0]  addr,
    // store side
    input  wire        st_v,
    input  wire [15:0] st_d,
    // read buses
    output wire [15:0] drb,
    output wire [15:0] prb
);
    reg [15:0] mem [0:15];
    initial begin
        mem[0] = 16'h0005;
        mem[1] = 16'h7fff;
        mem[2] = 16'h8000;
        mem[3] = 16'hffff;
        mem[4] = 16'h1234;
        mem[5] = 16'h0003;
        mem[6] = 16'h0200;
        mem[7] = 16'h0001;
        mem[8] = 16'h5678;
    end
    // every store lands in the top word so the bench can read it back
    always @(posedge clk) begin
        if (st_v)
            mem[15] <= st_d;
    end
    assign drb = mem[addr];
    assign prb = ~mem[addr];
endmodule // dmad_mem_model

//--- dmad_datapath_test.sv
// self-checking bench for the multiply / alu datapath
`timescale 1ns/1ps
`include "dmad_regs.vh"
module dmad_datapath_test;
    reg         clk = 1'b0, rst = 1'b1;
    reg  [5:0]  op = 6'h00;
    reg  [3:0]  adr = 4'h0;
    reg  [4:0]  sh = 5'h00;
    reg  [2:0]  ps = 3'h0, asel = 3'h0;
    reg  [15:0] imm = 16'h0000;
    reg         sat = 1'b0, sgn = 1'b1, ovc = 1'b0;
    reg  [1:0]  psm = 2'h0, amod = 2'h0, asrc = `DMAD_SRC_IMM;
    reg         ald = 1'b0, apl = 1'b0, aac = 1'b0, srcp = 1'b0;
    reg  [31:0] e;
    wire [31:0] acc, prod;
    wire [15:0] drb, prb, mop, std, jad, aad;
    wire        cy, ovf, zc, tf, stv, jv, av;
    wire [2:0]  ap;
    integer     fails = 0, n_checks = 0, cyc = 0, k;

    dmad_mem_model mem (.clk(clk), .addr(adr), .st_v(stv), .st_d(std),
        .drb(drb), .prb(prb));
    dmad_datapath dut (.CLK_SYS(clk), .RST(rst), .OP(op), .SHIFT_CNT(sh),
        .POST_SHIFT(ps), .SRC_PROG(srcp), .IMM(imm), .DATA_READ_BUS(drb),
        .PROGRAM_READ_BUS(prb), .SATURATE_ENABLE(sat),
        .SIGN_EXTEND_ENABLE(sgn), .PRODUCT_SHIFT_MODE(psm),
        .OVERFLOW_CLEAR(ovc), .AUX_LOAD(ald), .AUX_LOAD_SEL(asel),
        .AUX_SRC(asrc), .AUX_PTR_LOAD(apl), .AUX_ACCESS(aac),
        .AUX_MOD(amod), .ACC(acc), .PRODUCT(prod), .MULT_OPERAND(mop),
        .CARRY(cy), .OVERFLOW(ovf), .ZERO_COND(zc), .TEST_FLAG(tf),
        .STORE_DATA(std), .STORE_VALID(stv), .JUMP_ADDR(jad),
        .JUMP_VALID(jv), .AUX_ADDR(aad), .AUX_ADDR_VALID(av),
        .AUX_PTR(ap));

    initial forever #2 clk = ~clk;

    task print_verdict;
        begin
            $display("checks %0d fails %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    // a hung run still reaches the closing report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails = fails + 1;
            print_verdict;
        end
    end

    task chk(input [8*6:1] nm, input [47:0] ex, input [47:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== ex) begin
                fails = fails + 1;
                $display("CHECK FAILED %0s exp %h got %h", nm, ex, got);
            end
        end
    endtask

    // one op per call, results read 1 ns after the edge that takes it
    task run(input [5:0] o, input [3:0] a, input [4:0] s, input [15:0] i);
        begin
            @(posedge clk);
            op <= o;
            adr <= a;
            sh <= s;
            imm <= i;
            @(posedge clk);
            op <= `DMAD_OP_NOP;
            #1;
        end
    endtask

    task step(input [5:0] o, input [3:0] a, input [4:0] s, input [32:0] x);
        begin
            run(o, a, s, 16'h0000);
            chk("cy_acc", x, {cy, acc});
        end
    endtask

    task aux(input l, input p, input x, input [1:0] m, input [2:0] s,
             input [15:0] i, input [18:0] ex);
        begin
            @(posedge clk);
            ald <= l;
            apl <= p;
            aac <= x;
            amod <= m;
            asel <= s;
            imm <= i;
            @(posedge clk);
            ald <= 1'b0;
            apl <= 1'b0;
            aac <= 1'b0;
            #1;
            chk("aux", ex, {ap, aad});
        end
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset", {2'b11, 32'h0}, {cy, zc, acc});
        step(`DMAD_OP_ADD, 4'h0, 5'h00, {1'b0, 32'h5});
        run(`DMAD_OP_LOAD_MULT, 4'h3, 5'h00, 16'h0000);
        chk("mop", 16'hffff, mop);
        run(`DMAD_OP_UMUL, 4'h3, 5'h00, 16'h0000);
        chk("umul", 32'hfffe0001, prod);
        run(`DMAD_OP_MUL_IMM, 4'h0, 5'h00, 16'h0000);
        chk("mul0", 32'h0, prod);
        run(`DMAD_OP_LOAD_MULT, 4'h4, 5'h00, 16'h0000);
        run(`DMAD_OP_MUL_IMM, 4'h0, 5'h00, 16'h0001);
        run(`DMAD_OP_PHLD, 4'h2, 5'h00, 16'h0000);
        chk("rest", 32'h80001234, prod);
        for (k = 0; k < 4; k = k + 1) begin
            @(posedge clk) psm <= k[1:0];
            e = (k == 3) ? 32'hfe000048 : 32'h80001234 << (k * k);
            run(`DMAD_OP_LOAD_PROD, 4'h0, 5'h00, 16'h0000);
            chk("product_shifter", e, acc);
            run(`DMAD_OP_PSTL, 4'h0, 5'h00, 16'h0000);
            chk("spl", e[15:0], std);
        end
        run(`DMAD_OP_SQAD, 4'h5, 5'h00, 16'h0000);
        chk("square", 32'h9, prod);
        @(posedge clk) sat <= 1'b1;
        run(`DMAD_OP_LOAD_ACC, 4'h1, 5'h10, 16'h0000);
        run(`DMAD_OP_ADD, 4'h1, 5'h10, 16'h0000);
        chk("satp", {1'b1, 32'h7fffffff}, {ovf, acc});
        run(`DMAD_OP_LOAD_ACC, 4'h2, 5'h10, 16'h0000);
        run(`DMAD_OP_SUB, 4'h7, 5'h00, 16'h0000);
        chk("satn", {1'b1, 32'h80000000}, {ovf, acc});
        @(posedge clk) sat <= 1'b0;
        ovc <= 1'b1;
        @(posedge clk) ovc <= 1'b0;
        run(`DMAD_OP_LOAD_ACC, 4'h1, 5'h10, 16'h0000);
        run(`DMAD_OP_ADD, 4'h1, 5'h10, 16'h0000);
        chk("wrap", {1'b1, 32'hfffe0000}, {ovf, acc});
        @(posedge clk) ovc <= 1'b1;
        @(posedge clk) ovc <= 1'b0;
        run(`DMAD_OP_OR, 4'h2, 5'h10, 16'h0000);
        chk("logov", {1'b0, 32'hfffe0000}, {ovf, acc});
        run(`DMAD_OP_CLR_CARRY, 4'h0, 5'h00, 16'h0000);
        @(posedge clk) sgn <= 1'b0;
        step(`DMAD_OP_LOAD_ACC, 4'h3, 5'h10, {1'b0, 32'hffff0000});
        step(`DMAD_OP_ADD, 4'h7, 5'h10, {1'b1, 32'h0});
        step(`DMAD_OP_ADD, 4'h7, 5'h10, {1'b1, 32'h10000});
        step(`DMAD_OP_SUB, 4'h7, 5'h10, {1'b1, 32'h0});
        step(`DMAD_OP_SUB, 4'h7, 5'h10, {1'b0, 32'hffff0000});
        run(`DMAD_OP_SET_CARRY, 4'h0, 5'h00, 16'h0000);
        step(`DMAD_OP_LOAD_ACC, 4'h0, 5'h00, {1'b1, 32'h5});
        step(`DMAD_OP_ADCY, 4'h0, 5'h00, {1'b0, 32'hb});
        step(`DMAD_OP_SBCY, 4'h0, 5'h00, {1'b1, 32'h5});
        step(`DMAD_OP_XOR, 4'h4, 5'h00, {1'b1, 32'h1231});
        run(`DMAD_OP_CLR_CARRY, 4'h0, 5'h00, 16'h0000);
        step(`DMAD_OP_LOAD_STATUS1, 4'h6, 5'h00, {1'b1, 32'h1231});
        step(`DMAD_OP_LOAD_ACC, 4'h2, 5'h10, {1'b1, 32'h80000000});
        @(posedge clk) sgn <= 1'b1;
        step(`DMAD_OP_SHR, 4'h0, 5'h00, {1'b0, 32'hc0000000});
        @(posedge clk) sgn <= 1'b0;
        step(`DMAD_OP_SHR, 4'h0, 5'h00, {1'b0, 32'h60000000});
        step(`DMAD_OP_SHL, 4'h0, 5'h00, {1'b0, 32'hc0000000});
        step(`DMAD_OP_SHL, 4'h0, 5'h00, {1'b1, 32'h80000000});
        step(`DMAD_OP_RLC, 4'h0, 5'h00, {1'b1, 32'h1});
        step(`DMAD_OP_RRC, 4'h0, 5'h00, {1'b1, 32'h80000000});
        run(`DMAD_OP_LOAD_MULT, 4'h5, 5'h00, 16'h0000);
        step(`DMAD_OP_LOAD_ACC_VAR, 4'h0, 5'h00, {1'b1, 32'h28});
        step(`DMAD_OP_LEADING_SHIFT_OP, 4'h0, 5'h00, {1'b1, 32'h50});
        run(`DMAD_OP_BIT_VAR, 4'h4, 5'h00, 16'h0000);
        chk("bitvar", 1'b1, tf);
        run(`DMAD_OP_BIT, 4'h4, 5'h00, 16'h0000);
        chk("bit", {1'b0, 32'h50}, {tf, acc});
        run(`DMAD_OP_JUMP_ACC, 4'h0, 5'h00, 16'h0000);
        chk("jump", {2'b10, 16'h0050}, {jv, zc, jad});
        step(`DMAD_OP_LOAD_ACC, 4'h4, 5'h10, {1'b1, 32'h12340000});
        step(`DMAD_OP_ADD, 4'h8, 5'h00, {1'b0, 32'h12345678});
        @(posedge clk) ps <= 3'h4;
        run(`DMAD_OP_STORE_HIGH, 4'h0, 5'h00, 16'h0000);
        chk("sthi", {1'b1, 16'h2345}, {stv, std});
        run(`DMAD_OP_STORE_LOW, 4'h0, 5'h00, 16'h0000);
        chk("stlo", {16'h6780, 32'h12345678}, {std, acc});
        step(`DMAD_OP_LOAD_ACC, 4'hf, 5'h00, {1'b0, 32'h6780});
        @(posedge clk) srcp <= 1'b1;
        step(`DMAD_OP_ADD, 4'h0, 5'h00, {1'b0, 32'h1677a});
        aux(1'b1, 1'b0, 1'b0, 2'h0, 3'h0, 16'h0100, {3'h0, 16'h0});
        aux(1'b0, 1'b0, 1'b1, 2'h1, 3'h0, 16'h0, {3'h0, 16'h0100});
        aux(1'b0, 1'b0, 1'b1, 2'h3, 3'h0, 16'h0, {3'h0, 16'h0101});
        aux(1'b0, 1'b0, 1'b1, 2'h2, 3'h0, 16'h0, {3'h0, 16'h0202});
        aux(1'b0, 1'b0, 1'b1, 2'h0, 3'h0, 16'h0, {3'h0, 16'h0201});
        aux(1'b1, 1'b1, 1'b0, 2'h0, 3'h5, 16'h5, {3'h5, 16'h0201});
        aux(1'b0, 1'b0, 1'b1, 2'h0, 3'h0, 16'h0, {3'h5, 16'h0005});
        @(posedge clk) asrc <= `DMAD_SRC_ACC;
        aux(1'b1, 1'b1, 1'b0, 2'h0, 3'h2, 16'h0, {3'h2, 16'h0005});
        aux(1'b0, 1'b0, 1'b1, 2'h0, 3'h0, 16'h0, {3'h2, 16'h677a});
        print_verdict;
    end
endmodule // dmad_datapath_test

bind dmad_datapath dmad_datapath_asserts u_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .OP(OP), .IMM(IMM),
    .POST_SHIFT(POST_SHIFT), .DATA_READ_BUS(DATA_READ_BUS),
    .AUX_ACCESS(AUX_ACCESS), .ACC(ACC), .PRODUCT(PRODUCT),
    .MULT_OPERAND(MULT_OPERAND), .CARRY(CARRY), .STORE_DATA(STORE_DATA),
    .STORE_VALID(STORE_VALID), .JUMP_ADDR(JUMP_ADDR),
    .JUMP_VALID(JUMP_VALID), .AUX_ADDR_VALID(AUX_ADDR_VALID));
